// ---- hdl/usc_uart.sv ----
// asynchronous serial channel with register slave on Avalon-MM
module usc_uart (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register bus
    input wire usc_pkg::usc_av_req_t av_req,
    output logic [31:0] av_readdata,
    output logic av_waitrequest,
    // serial line
    output logic serial_out_pin,
    input wire logic serial_in_pin,
    input wire logic serial_clock_pin,
    output logic serial_clock_is_gpio,
    // flow control pins
    input wire logic clear_to_send_in,
    input wire logic clear_to_send_alt_in,
    output logic request_to_send_out,
    output logic request_to_send_oe,
    // interrupt requests
    output logic tx_irq_req,
    output logic rx_irq_req
);
    logic [7:0] uart_frame_mode;
    logic [7:0] uart_control_zero;
    logic [7:0] serial_pin_control;
    logic [7:0] bit_rate;
    logic transmit_enable_flag;
    logic tx_buffer_empty;
    logic receive_enable_flag;
    logic rx_full;
    logic overrun_error_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic tx_register_empty_flag;
    logic [8:0] tx_buffer;
    logic [8:0] rx_buffer;

    // length decode; other codes idle the channel
    function automatic logic [3:0] data_len(input logic [2:0] m);
        if (m == usc_pkg::LEN_SEVEN) begin
            data_len = 4'h7;
        end else if (m == usc_pkg::LEN_EIGHT) begin
            data_len = 4'h8;
        end else if (m == usc_pkg::LEN_NINE) begin
            data_len = 4'h9;
        end else begin
            data_len = 4'h0;
        end
    endfunction

    function automatic logic [3:0] frame_bits(input logic [7:0] fm);
        frame_bits = 4'h2 + data_len(fm[2:0]) + {3'h0, fm[usc_pkg::FM_PAR_EN]} + {3'h0, fm[usc_pkg::FM_TWO_STOP]};
    endfunction

    function automatic logic [8:0] mask_data(input logic [8:0] d, input logic [3:0] len);
        logic [8:0] r;
        r = 9'h000;
        for (int i = 0; i < 9; i++) begin
            if (i < len) begin
                r[i] = d[i];
            end
        end
        mask_data = r;
    endfunction

    // parity sense; odd inverts the even bit
    function automatic logic par_bit(input logic [8:0] d, input logic even);
        par_bit = (^d) ^ ~even;
    endfunction

    wire logic [3:0] len = data_len(uart_frame_mode[2:0]);
    wire logic [3:0] nbits = frame_bits(uart_frame_mode);
    wire logic par_en = uart_frame_mode[usc_pkg::FM_PAR_EN];
    wire logic even_par = uart_frame_mode[usc_pkg::FM_EVEN_PAR];
    wire logic two_stop = uart_frame_mode[usc_pkg::FM_TWO_STOP];
    wire logic len_ok = (len != 4'h0);

    // bus slave: one wait cycle, then the access completes
    wire logic acc = (av_req.read | av_req.write) & ~av_waitrequest;
    wire logic wr = av_req.write & acc & av_req.byteenable[0];
    wire logic rx_rd = av_req.read & acc & (av_req.address == usc_pkg::OFS_RX_BUFFER);
    wire logic wr_c1 = wr & (av_req.address == usc_pkg::OFS_CONTROL_ONE);
    wire logic rx_disable = wr_c1 & ~av_req.writedata[usc_pkg::C1_RX_EN];
    wire logic tx_wr = wr & (av_req.address == usc_pkg::OFS_TX_BUFFER);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            av_waitrequest <= 1'b1;
        end else if ((av_req.read | av_req.write) & av_waitrequest) begin
            av_waitrequest <= 1'b0;
        end else begin
            av_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            av_readdata <= 32'h0000_0000;
        end else if (av_req.address == usc_pkg::OFS_FRAME_MODE) begin
            av_readdata <= {24'h00_0000, uart_frame_mode};
        end else if (av_req.address == usc_pkg::OFS_CONTROL_ZERO) begin
            av_readdata <= {24'h00_0000, uart_control_zero[7:4], tx_register_empty_flag, uart_control_zero[2:0]};
        end else if (av_req.address == usc_pkg::OFS_CONTROL_ONE) begin
            av_readdata <= {24'h00_0000, overrun_error_flag | framing_error_flag | parity_error_flag,
                parity_error_flag, framing_error_flag, overrun_error_flag, rx_full,
                receive_enable_flag, tx_buffer_empty, transmit_enable_flag};
        end else if (av_req.address == usc_pkg::OFS_PIN_CONTROL) begin
            av_readdata <= {24'h00_0000, serial_pin_control};
        end else if (av_req.address == usc_pkg::OFS_RX_BUFFER) begin
            av_readdata <= {23'h00_0000, rx_buffer};
        end else if (av_req.address == usc_pkg::OFS_BIT_RATE) begin
            av_readdata <= {24'h00_0000, bit_rate};
        end else begin
            av_readdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            uart_frame_mode <= usc_pkg::RST_FRAME_MODE;
            uart_control_zero <= usc_pkg::RST_CONTROL_ZERO;
            serial_pin_control <= usc_pkg::RST_PIN_CONTROL;
            bit_rate <= usc_pkg::RST_BIT_RATE;
            transmit_enable_flag <= 1'b0;
            receive_enable_flag <= 1'b0;
        end else if (wr) begin
            if (av_req.address == usc_pkg::OFS_FRAME_MODE) begin
                uart_frame_mode <= av_req.writedata[7:0];
            end else if (av_req.address == usc_pkg::OFS_CONTROL_ZERO) begin
                uart_control_zero <= av_req.writedata[7:0];
            end else if (av_req.address == usc_pkg::OFS_PIN_CONTROL) begin
                serial_pin_control <= av_req.writedata[7:0];
            end else if (av_req.address == usc_pkg::OFS_BIT_RATE) begin
                bit_rate <= av_req.writedata[7:0];
            end else if (av_req.address == usc_pkg::OFS_CONTROL_ONE) begin
                transmit_enable_flag <= av_req.writedata[usc_pkg::C1_TX_EN];
                receive_enable_flag <= av_req.writedata[usc_pkg::C1_RX_EN];
            end
        end
    end

    wire logic flow_on = ~uart_control_zero[usc_pkg::C0_FLOW_OFF];
    wire logic separated = serial_pin_control[1:0] == usc_pkg::PC_SEPARATE;
    wire logic rts_on = flow_on & (separated | uart_control_zero[usc_pkg::C0_RTS_SEL]);
    wire logic cts_on = flow_on & (separated | ~uart_control_zero[usc_pkg::C0_RTS_SEL]);
    wire logic cts_level = separated ? clear_to_send_alt_in : clear_to_send_in;
    wire logic cts_low = ~cts_on | ~cts_level;

    logic [8:0] presc;
    logic ext_clk_q;
    logic src_tick;
    logic [8:0] tap;
    always_comb begin
        case (uart_control_zero[1:0])
            2'h0: tap = usc_pkg::PRESC_MASK_1;
            2'h1: tap = usc_pkg::PRESC_MASK_8;
            2'h2: tap = usc_pkg::PRESC_MASK_32;
            default: tap = usc_pkg::PRESC_MASK_512;
        endcase
        if (uart_frame_mode[usc_pkg::FM_EXT_CLK]) begin
            src_tick = serial_clock_pin & ~ext_clk_q;
        end else begin
            src_tick = (presc & tap) == 9'h000;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            presc <= 9'h000;
            ext_clk_q <= 1'b0;
            serial_clock_is_gpio <= 1'b1;
        end else begin
            presc <= presc + 9'h001;
            ext_clk_q <= serial_clock_pin;
            serial_clock_is_gpio <= ~uart_frame_mode[usc_pkg::FM_EXT_CLK] & ~separated;
        end
    end

    // divide by n plus one gives the sixteen-times bit tick
    logic [7:0] brg;
    logic tick16;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            brg <= 8'h00;
            tick16 <= 1'b0;
        end else begin
            tick16 <= src_tick & (brg == 8'h00);
            if (src_tick) begin
                brg <= (brg == 8'h00) ? bit_rate : brg - 8'h01;
            end
        end
    end

    // transmitter
    usc_pkg::usc_tx_state_t tx_state;
    logic [12:0] tx_shift;
    logic [3:0] tx_left;
    logic [3:0] tx_sub;
    logic tend_q;
    logic tx_empty_q;
    wire logic tend = (tx_state == usc_pkg::TX_IDLE);
    // start conditions sampled only while transmit end is high
    wire logic tx_start = tend & transmit_enable_flag & ~tx_buffer_empty & cts_low & len_ok;
    wire logic [8:0] tx_data = mask_data(tx_buffer, len);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_state <= usc_pkg::TX_IDLE;
            tx_shift <= 13'h1FFF;
            tx_left <= 4'h0;
            tx_sub <= 4'h0;
        end else if (tx_start) begin
            // start, data LSB first, optional parity, stops
            tx_state <= usc_pkg::TX_SHIFT;
            tx_shift <= ((13'h1FFF << (len + 4'h1)) | {3'h0, tx_data, 1'b0})
                & ~({12'h000, par_en & ~par_bit(tx_data, even_par)} << (len + 4'h1));
            tx_left <= nbits;
            tx_sub <= 4'h0;
        end else if (tx_state == usc_pkg::TX_SHIFT && tick16) begin
            // frame runs to its end regardless of enable or clear-to-send
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == usc_pkg::SUB_LAST) begin
                tx_shift <= {1'b1, tx_shift[12:1]};
                tx_left <= tx_left - 4'h1;
                if (tx_left == 4'h1) begin
                    tx_state <= usc_pkg::TX_IDLE;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_buffer <= 9'h000;
            tx_buffer_empty <= 1'b1;
            tx_irq_req <= 1'b0;
        end else begin
            if (tx_wr) begin
                tx_buffer <= {av_req.byteenable[1] & av_req.writedata[8], av_req.writedata[7:0]};
                tx_buffer_empty <= 1'b0;
            end else if (tx_start) begin
                tx_buffer_empty <= 1'b1;
            end
            tx_irq_req <= tx_start & ~tx_wr;
        end
    end

    // tx empty flag one cycle after transmit end rises
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tend_q <= 1'b1;
            tx_empty_q <= 1'b1;
            serial_out_pin <= 1'b1;
        end else begin
            tend_q <= tend;
            if (tx_start) begin
                tx_empty_q <= 1'b0;
            end else if (tend && !tend_q) begin
                tx_empty_q <= 1'b1;
            end
            serial_out_pin <= (tx_state == usc_pkg::TX_SHIFT) ? tx_shift[0] : 1'b1;
        end
    end
    assign tx_register_empty_flag = tx_empty_q;

    // receiver
    usc_pkg::usc_rx_state_t rx_state;
    logic rxd_q;
    logic [12:0] rx_shift;
    logic [3:0] rx_idx;
    logic [3:0] rx_sub;
    logic rx_done;
    // start bit seen as a falling edge
    wire logic rx_begin = (rx_state == usc_pkg::RX_IDLE) & receive_enable_flag & len_ok & rxd_q & ~serial_in_pin;
    wire logic [8:0] rx_data = mask_data(rx_shift[9:1] >> 0, len) | 9'h000;
    wire logic rx_par = rx_shift[len + 4'h1];
    wire logic [3:0] stop_pos = len + 4'h1 + {3'h0, par_en};
    wire logic fer_now = ~rx_shift[stop_pos] | (two_stop & ~rx_shift[stop_pos + 4'h1]);
    wire logic per_now = par_en & (rx_par != par_bit(rx_data, even_par));
    // sleep filter on top data bit
    wire logic rx_keep = ~uart_frame_mode[usc_pkg::FM_SLEEP] | rx_data[len - 4'h1];
    wire logic rx_commit = rx_done & rx_keep;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_state <= usc_pkg::RX_IDLE;
            rxd_q <= 1'b1;
            rx_shift <= 13'h1FFF;
            rx_idx <= 4'h0;
            rx_sub <= 4'h0;
            rx_done <= 1'b0;
        end else begin
            rxd_q <= serial_in_pin;
            rx_done <= 1'b0;
            if (rx_begin) begin
                rx_state <= usc_pkg::RX_BITS;
                rx_idx <= 4'h0;
                rx_sub <= 4'h0;
            end else if (rx_state == usc_pkg::RX_BITS && (rx_disable || !receive_enable_flag)) begin
                rx_state <= usc_pkg::RX_IDLE;
            end else if (rx_state == usc_pkg::RX_BITS && tick16) begin
                rx_sub <= rx_sub + 4'h1;
                if (rx_sub == usc_pkg::SUB_MID) begin
                    rx_shift[rx_idx] <= rxd_q;
                    rx_idx <= rx_idx + 4'h1;
                    if (rx_idx == 4'h0 && rxd_q) begin
                        // glitch, not a start bit
                        rx_state <= usc_pkg::RX_IDLE;
                    end else if (rx_idx == nbits - 4'h1) begin
                        rx_state <= usc_pkg::RX_IDLE;
                        rx_done <= 1'b1;
                    end
                end
            end
        end
    end

    // buffer and flags; a new frame wins over a clearing read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_buffer <= 9'h000;
            rx_full <= 1'b0;
            overrun_error_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            parity_error_flag <= 1'b0;
        end else if (rx_disable) begin
            rx_full <= 1'b0;
            overrun_error_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            parity_error_flag <= 1'b0;
        end else if (rx_commit) begin
            rx_buffer <= rx_data;
            rx_full <= 1'b1;
            overrun_error_flag <= overrun_error_flag | rx_full;
            framing_error_flag <= fer_now;
            parity_error_flag <= per_now;
        end else if (rx_rd) begin
            rx_full <= 1'b0;
            framing_error_flag <= 1'b0;
            parity_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_irq_req <= 1'b0;
        end else begin
            rx_irq_req <= rx_commit & ~rx_disable
                & (~uart_control_zero[usc_pkg::C0_RX_IRQ_ERR] | rx_full | fer_now | per_now);
        end
    end

    // request-to-send handshake; a dropped or aborted frame releases it
    logic rts_busy;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rts_busy <= 1'b0;
            request_to_send_out <= 1'b1;
            request_to_send_oe <= 1'b0;
        end else begin
            if (!receive_enable_flag || rx_disable) begin
                rts_busy <= 1'b0;
            end else if (rx_begin) begin
                rts_busy <= 1'b1;
            end else if (rx_rd && !rx_commit) begin
                rts_busy <= 1'b0;
            end else if (rx_state == usc_pkg::RX_IDLE && !rx_done && !rx_full) begin
                rts_busy <= 1'b0;
            end
            request_to_send_out <= ~receive_enable_flag | rx_begin | rts_busy;
            request_to_send_oe <= rts_on;
        end
    end

    AST_TX_WRITE_CLEARS: assert property (@(posedge clk) disable iff (!rst_b)
        tx_wr |=> !tx_buffer_empty) else $error("buffer empty flag not cleared by write");
    AST_TX_START_COND: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(tx_state == usc_pkg::TX_SHIFT) |-> $past(transmit_enable_flag && !tx_buffer_empty && cts_low))
        else $error("frame started without its conditions");
    AST_TX_EMPTY_LAG: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(tend) && !tx_start |=> tx_register_empty_flag) else $error("tx empty flag late");
    AST_TX_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(tx_buffer_empty) |-> tx_irq_req) else $error("no transmit request on buffer empty");
    AST_RTS_DISABLED: assert property (@(posedge clk) disable iff (!rst_b)
        !receive_enable_flag ##1 !receive_enable_flag |-> request_to_send_out) else $error("request low while disabled");
    AST_OVERRUN: assert property (@(posedge clk) disable iff (!rst_b)
        rx_commit && rx_full && !rx_disable |=> overrun_error_flag) else $error("overrun missed");
    AST_READ_CLEARS: assert property (@(posedge clk) disable iff (!rst_b)
        rx_rd && !rx_commit |=> !rx_full && !framing_error_flag) else $error("read did not clear flags");
    AST_SLEEP_DROP: assert property (@(posedge clk) disable iff (!rst_b)
        rx_done && !rx_keep && !rx_rd && !rx_disable |=> $stable(rx_full) && $stable(rx_buffer) && !rx_irq_req)
        else $error("sleep frame was buffered");
endmodule

// ---- hdl/usc_pkg.sv ----
// package: register map, field positions, reset values and bus carrier for the serial channel
package usc_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_FRAME_MODE = 5'h00;
    localparam logic [4:0] OFS_CONTROL_ZERO = 5'h04;
    localparam logic [4:0] OFS_CONTROL_ONE = 5'h08;
    localparam logic [4:0] OFS_PIN_CONTROL = 5'h0C;
    localparam logic [4:0] OFS_TX_BUFFER = 5'h10;
    localparam logic [4:0] OFS_RX_BUFFER = 5'h14;
    localparam logic [4:0] OFS_BIT_RATE = 5'h18;
    // frame mode fields
    localparam int FM_LEN_LSB = 0;
    localparam int FM_EXT_CLK = 3;
    localparam int FM_TWO_STOP = 4;
    localparam int FM_EVEN_PAR = 5;
    localparam int FM_PAR_EN = 6;
    localparam int FM_SLEEP = 7;
    localparam logic [2:0] LEN_SEVEN = 3'h4;
    localparam logic [2:0] LEN_EIGHT = 3'h5;
    localparam logic [2:0] LEN_NINE = 3'h6;
    // control zero fields
    localparam int C0_CLK_SEL_LSB = 0;
    localparam int C0_RTS_SEL = 2;
    localparam int C0_TX_EMPTY = 3;
    localparam int C0_FLOW_OFF = 4;
    localparam int C0_RX_IRQ_ERR = 5;
    // control one fields
    localparam int C1_TX_EN = 0;
    localparam int C1_TX_BUF_EMPTY = 1;
    localparam int C1_RX_EN = 2;
    localparam int C1_RX_FULL = 3;
    localparam int C1_OVERRUN = 4;
    localparam int C1_FRAMING = 5;
    localparam int C1_PARITY = 6;
    localparam int C1_SUMMARY = 7;
    // pin control: flow-control separation field
    localparam int PC_SEP_LSB = 0;
    localparam logic [1:0] PC_SEPARATE = 2'h3;
    // reset values
    localparam logic [7:0] RST_FRAME_MODE = 8'h00;
    localparam logic [7:0] RST_CONTROL_ZERO = 8'h00;
    localparam logic [7:0] RST_PIN_CONTROL = 8'h00;
    localparam logic [7:0] RST_BIT_RATE = 8'h00;
    // internal prescaler taps: divide by 1, 8, 32, 512
    localparam int PRESC_BITS = 9;
    localparam logic [8:0] PRESC_MASK_1 = 9'h000;
    localparam logic [8:0] PRESC_MASK_8 = 9'h007;
    localparam logic [8:0] PRESC_MASK_32 = 9'h01F;
    localparam logic [8:0] PRESC_MASK_512 = 9'h1FF;
    // oversampling: sixteen ticks per bit, sample in the middle
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] SUB_MID = 4'h7;
    localparam int FRAME_MAX = 13;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } usc_av_req_t;

    typedef enum logic {TX_IDLE, TX_SHIFT} usc_tx_state_t;
    typedef enum logic {RX_IDLE, RX_BITS} usc_rx_state_t;
endpackage

// ---- verif/usc_peer.sv ----
// far-side serial node: sends frames to the channel and captures its frames
module usc_peer (
    // clock
    input wire logic clk,
    // serial lines and clear-to-send
    input wire logic line_in,
    output logic line_out,
    output logic cts_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] got = 11'h7FF;
    int n = 0;
    initial begin
        line_out = 1'b1;
        cts_b = 1'b1;
    end
    task automatic hold_off(input logic v);
        cts_b <= v;
    endtask
    // start low, LSB first, stop then idle high
    task automatic send(input logic [7:0] d, input logic par, input logic stp);
        logic [10:0] f;
        f = {stp, par, d, 1'b0};
        for (int i = 0; i < 12; i++) begin
            line_out <= (i < 11) ? f[i] : 1'b1;
            repeat (16) @(posedge clk);
        end
    endtask
    always begin
        @(negedge line_in);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            got[i] = line_in;
            if (i < 10) repeat (16) @(posedge clk);
        end
        n++;
    end
endmodule

// ---- verif/usc_uart_tb.sv ----
// self-checking bench for the serial channel against a far-side node model
module usc_uart_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] C0 = usc_pkg::OFS_CONTROL_ZERO;
    localparam logic [4:0] C1 = usc_pkg::OFS_CONTROL_ONE;
    localparam logic [4:0] RXB = usc_pkg::OFS_RX_BUFFER;
    typedef struct packed {logic [4:0] a; logic [7:0] v;} usc_row_t;
    usc_row_t rows [6] = '{'{usc_pkg::OFS_FRAME_MODE, 8'h00}, '{C0, 8'h08}, '{C1, 8'h02},
        '{usc_pkg::OFS_PIN_CONTROL, 8'h00}, '{usc_pkg::OFS_BIT_RATE, 8'h00}, '{5'h1C, 8'h00}};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    usc_pkg::usc_av_req_t av_req = '0;
    logic [31:0] av_readdata;
    logic [31:0] q_rd;
    logic av_waitrequest, txd, rxd, cts_b, tx_irq, rx_irq, rts_b, rts_oe, clk_gpio;
    int fail_count = 0;
    int checked = 0;
    int n_tx = 0;
    int n_rx = 0;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (tx_irq === 1'b1) n_tx <= n_tx + 1;
        if (rx_irq === 1'b1) n_rx <= n_rx + 1;
    end
    usc_uart i_usc_uart (.clk(clk), .rst_b(rst_b), .av_req(av_req), .av_readdata(av_readdata),
        .av_waitrequest(av_waitrequest), .serial_out_pin(txd), .serial_in_pin(rxd), .serial_clock_pin(1'b0),
        .serial_clock_is_gpio(clk_gpio), .clear_to_send_in(cts_b), .clear_to_send_alt_in(1'b1),
        .request_to_send_out(rts_b), .request_to_send_oe(rts_oe), .tx_irq_req(tx_irq), .rx_irq_req(rx_irq));
    usc_peer i_usc_peer (.clk(clk), .line_in(txd), .line_out(rxd), .cts_b(cts_b));
    task automatic final_report();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
        int k;
        k = 0;
        av_req <= '{read: !w, write: w, address: a, byteenable: 4'hF, writedata: {24'h0, d}};
        do begin
            @(posedge clk);
            k++;
        end while (av_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) begin
            fail_count++;
            final_report();
        end
        q = av_readdata;
        av_req <= '0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d, q_rd);
    endtask
    task automatic expect_reg(input string what, input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, q_rd);
        chk(what, {24'h0, e}, q_rd);
    endtask
    task automatic await(ref int v, input int t);
        int k;
        k = 0;
        while (v < t && k < 4000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 4000) fail_count++;
        if (k >= 4000) final_report();
    endtask
    // one received frame, then control one compared
    task automatic rx(input logic [7:0] d, input logic bad_par, input logic stp, input logic [7:0] e1);
        i_usc_peer.send(d, ~^d ^ bad_par, stp);
        expect_reg("control one", C1, e1);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) expect_reg("reset value", rows[i].a, rows[i].v);
        chk("clock pin free", 32'h1, {31'h0, clk_gpio});
        chk("request pin off", 32'h0, {31'h0, rts_oe});
        $display("test reset values done");
        wr(usc_pkg::OFS_FRAME_MODE, 8'h45);
        wr(C1, 8'h05);
        wr(usc_pkg::OFS_TX_BUFFER, 8'hA5);
        expect_reg("held off", C1, 8'h05);
        chk("tx loads", 32'h0, n_tx);
        i_usc_peer.hold_off(1'b0);
        await(n_tx, 1);
        wr(usc_pkg::OFS_TX_BUFFER, 8'h07);
        expect_reg("tx busy", C0, 8'h00);
        await(i_usc_peer.n, 1);
        chk("frame one", {21'h0, 2'h3, 8'hA5, 1'b0}, {21'h0, i_usc_peer.got});
        await(i_usc_peer.n, 2);
        chk("frame two", {21'h0, 2'h2, 8'h07, 1'b0}, {21'h0, i_usc_peer.got});
        chk("tx requests", 32'h2, n_tx);
        repeat (16) @(posedge clk);
        expect_reg("tx done", C0, 8'h08);
        chk("request to send", 32'h0, {31'h0, rts_b});
        $display("test transmit done");
        rx(8'h3C, 1'b0, 1'b1, 8'h0F);
        chk("request to send", 32'h1, {31'h0, rts_b});
        expect_reg("rx data", RXB, 8'h3C);
        expect_reg("after read", C1, 8'h07);
        chk("request to send", 32'h0, {31'h0, rts_b});
        rx(8'h81, 1'b1, 1'b1, 8'hCF);
        rx(8'h42, 1'b1, 1'b1, 8'hDF);
        expect_reg("rx data", RXB, 8'h42);
        expect_reg("after read", C1, 8'h97);
        wr(C1, 8'h01);
        expect_reg("rx off", C1, 8'h03);
        chk("request to send", 32'h1, {31'h0, rts_b});
        chk("rx requests", 32'h3, n_rx);
        wr(C0, 8'h20);
        wr(C1, 8'h05);
        rx(8'h11, 1'b0, 1'b1, 8'h0F);
        chk("rx requests", 32'h3, n_rx);
        expect_reg("rx data", RXB, 8'h11);
        rx(8'h22, 1'b0, 1'b0, 8'hAF);
        chk("rx requests", 32'h4, n_rx);
        expect_reg("rx data", RXB, 8'h22);
        wr(usc_pkg::OFS_FRAME_MODE, 8'hC5);
        rx(8'h12, 1'b1, 1'b0, 8'h07);
        rx(8'h92, 1'b0, 1'b1, 8'h0F);
        expect_reg("rx data", RXB, 8'h92);
        chk("rx requests", 32'h4, n_rx);
        $display("test receive done");
        final_report();
    end
endmodule
